//--- scwm_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Code 00: interrupt at 8th, no wait state
// - Code 10 I2C: interrupt at 8th, hold clock low
// - Code 11 I2C: interrupt at 9th, hold clock low
// - Release bit ends wait, clears itself
// - Idle level bit 0: clock driven low
// - Idle level bit 1: clock floats idle
// - Mask bit drops address bit 0 compare
// - Cause bit adds stop condition interrupt
// - Clock level bit reads pin, 0 if off
// - Stopped: no shifting, plain register
// - Stopped: all three pins are ports
// - Enable bit starts or stops channel
// - Clock select: external, timer two, timer select
// - 3-wire mode, bit order, pin directions
// - Wake-up: byte interrupt only on address match after start
// - Transmit-only 3-wire frees data-in pin
// - Shift out falling, capture rising
// - After byte: stop, set interrupt
// - Shift register write starts transfer
module scwm_ctrl (
  // System clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // Link clock and its reset
  input  wire logic               link_clk,
  input  wire logic               link_rst,
  // CPU register port
  input  wire logic [15:0]        cpu_addr,
  input  wire logic               cpu_wr,
  input  wire logic               cpu_rd,
  input  wire logic [7:0]         cpu_wdata,
  output logic [7:0]              cpu_rdata,
  // Internal clock sources, one-cycle ticks
  input  wire logic               timer_two_output,
  input  wire logic               timer_clock_select,
  // Port latches, {clock, out, in}
  input  wire logic [2:0]         port_out,
  input  wire logic [2:0]         port_oe,
  // Serial pins
  input  wire logic               serial_clock_pin_in,
  input  wire logic               serial_in_pin_in,
  input  wire logic               serial_out_pin_in,
  output scwm_pkg::scwm_pin_t     serial_clock_pin,
  output scwm_pkg::scwm_pin_t     serial_in_pin,
  output scwm_pkg::scwm_pin_t     serial_out_pin,
  // Event
  output logic                    channel_interrupt
);
  scwm_pkg::scwm_mode_t      mode;
  scwm_pkg::scwm_wait_t      wcfg;
  scwm_pkg::scwm_state_t     state;
  scwm_pkg::scwm_wait_code_t wait_code;
  logic [7:0] sio;
  logic [7:0] slave_addr;
  logic [7:0] rx_word;
  logic [7:0] mask;
  logic [3:0] frame_len;
  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [4:0] edges;
  logic       wait_release;
  logic       addr_match;
  logic       start_tgl;
  logic       done_tgl;
  logic       done_seen;
  logic       done_evt;
  logic       so_bit;
  logic       sck_gen;
  logic       sda_prev;
  logic       sda;
  logic       scl;
  logic       start_seen;
  logic       start_cond;
  logic       stop_cond;
  logic       addr_hit;
  logic       en;
  logic       i2c;
  logic       master;
  logic       lsb;
  logic       tick;
  logic       pending;
  logic       go;
  logic       wr_mode;
  logic       wr_wait;
  logic       wr_sio;
  logic       wr_slave;
  logic       sdi;

  function automatic logic [7:0] rev8(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      rev8[i] = d[7 - i];
  endfunction : rev8

  assign en      = mode.channel_enable;
  assign i2c     = mode.mode_sel_hi & mode.mode_sel_mid;
  assign master  = mode.clk_src_hi;
  assign lsb     = !mode.mode_sel_hi & mode.bit_order_sel;
  assign tick    = mode.clk_src_lo ? timer_clock_select : timer_two_output;
  assign wr_mode = cpu_wr && cpu_addr == scwm_pkg::MODE_ADDR;
  assign wr_wait = cpu_wr && cpu_addr == scwm_pkg::WAIT_ADDR;
  assign wr_sio  = cpu_wr && cpu_addr == scwm_pkg::SHIFT_ADDR;
  assign wr_slave = cpu_wr && cpu_addr == scwm_pkg::SLAVE_ADDR;

  // Link still busy after an aborted frame blocks a new start
  assign pending = start_tgl != done_seen;
  assign go      = state == scwm_pkg::ST_IDLE && wr_sio && en && !pending;
  assign done_evt = sync2[3] != done_seen;
  assign scl     = sync2[2];
  assign sda     = mode.bit_order_sel ? sync2[1] : sync2[0];
  assign start_cond = en && i2c && scl && sda_prev && !sda;
  assign stop_cond  = en && i2c && scl && !sda_prev && sda;
  assign mask     = wcfg.address_mask_sel ? scwm_pkg::MASK_NO_B0 : scwm_pkg::MASK_ALL;
  assign addr_hit = ((rx_word ^ slave_addr) & mask) == 8'h00;
  assign sdi = i2c ? (mode.bit_order_sel ? serial_in_pin_in : serial_out_pin_in)
                   : serial_in_pin_in;

  scwm_link u_link (
    .link_clk  (link_clk),
    .link_rst  (link_rst),
    .start_tgl (start_tgl),
    .frame_len (frame_len),
    .tx_word   (sio),
    .sdi       (sdi),
    .so_bit    (so_bit),
    .done_tgl  (done_tgl),
    .rx_word   (rx_word)
  );

  // Pin and link-done synchronisers
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1     <= 4'h0;
      sync2     <= 4'h0;
      done_seen <= 1'b0;
      sda_prev  <= 1'b1;
    end else begin
      sync1     <= {done_tgl, serial_clock_pin_in, serial_in_pin_in, serial_out_pin_in};
      sync2     <= sync1;
      done_seen <= sync2[3];
      sda_prev  <= sda;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      mode <= scwm_pkg::scwm_mode_t'(scwm_pkg::RESET_VAL);
    else if (wr_mode)
      mode <= scwm_pkg::scwm_mode_t'(cpu_wdata & scwm_pkg::MODE_WMASK);
  end

  always_ff @(posedge clk) begin
    if (rst)
      wcfg <= scwm_pkg::scwm_wait_t'(scwm_pkg::RESET_VAL);
    else if (wr_wait)
      wcfg <= scwm_pkg::scwm_wait_t'(cpu_wdata & scwm_pkg::WAIT_WMASK);
  end

  // Software set wins over the self-clear
  always_ff @(posedge clk) begin
    if (rst)
      wait_release <= 1'b0;
    else if (wr_wait)
      wait_release <= cpu_wdata[2];
    else if (state != scwm_pkg::ST_WAIT)
      wait_release <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst)
      slave_addr <= scwm_pkg::RESET_VAL;
    else if (wr_slave)
      slave_addr <= cpu_wdata;
  end

  // Writes during a frame are dropped to keep the sent byte intact
  always_ff @(posedge clk) begin
    if (rst)
      sio <= scwm_pkg::RESET_VAL;
    else if (state == scwm_pkg::ST_SHIFT && done_evt)
      sio <= rx_word;
    else if (wr_sio && state != scwm_pkg::ST_SHIFT)
      sio <= lsb ? rev8(cpu_wdata) : cpu_wdata;
  end

  // Wait code and length are frozen per byte
  always_ff @(posedge clk) begin
    if (rst) begin
      start_tgl <= 1'b0;
      frame_len <= scwm_pkg::BITS_8;
      wait_code <= scwm_pkg::WAIT_NONE;
    end else if (go) begin
      start_tgl <= ~start_tgl;
      wait_code <= scwm_pkg::scwm_wait_code_t'({wcfg.wait_sel_hi, wcfg.wait_sel_lo});
      frame_len <= (i2c && wcfg.wait_sel_hi && wcfg.wait_sel_lo) ? scwm_pkg::BITS_9
                                                               : scwm_pkg::BITS_8;
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      state <= scwm_pkg::ST_IDLE;
    else if (!en)
      state <= scwm_pkg::ST_IDLE;
    else begin
      case (state)
        scwm_pkg::ST_IDLE:
          if (go)
            state <= scwm_pkg::ST_SHIFT;
        scwm_pkg::ST_SHIFT:
          if (done_evt)
            state <= (i2c && wait_code[1]) ? scwm_pkg::ST_WAIT : scwm_pkg::ST_IDLE;
        scwm_pkg::ST_WAIT:
          if (wait_release)
            state <= scwm_pkg::ST_IDLE;
        default:
          state <= scwm_pkg::ST_IDLE;
      endcase
    end
  end

  // Internal serial clock, idles high, starts with a falling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_gen <= 1'b1;
      edges   <= 5'h00;
    end else if (go) begin
      sck_gen <= 1'b1;
      edges   <= 5'h00;
    end else if (state == scwm_pkg::ST_SHIFT && master && tick && edges < {frame_len, 1'b0}) begin
      sck_gen <= ~sck_gen;
      edges   <= 5'(edges + 5'h01);
    end
  end

  always_ff @(posedge clk) begin
    if (rst)
      start_seen <= 1'b0;
    else
      start_seen <= en && (start_cond || (start_seen && !stop_cond && !go));
  end

  always_ff @(posedge clk) begin
    if (rst)
      addr_match <= 1'b0;
    else if (!en)
      addr_match <= 1'b0;
    else if (state == scwm_pkg::ST_SHIFT && done_evt)
      addr_match <= addr_hit;
  end

  always_ff @(posedge clk) begin
    if (rst)
      channel_interrupt <= 1'b0;
    else
      channel_interrupt <= (state == scwm_pkg::ST_SHIFT && done_evt &&
                            (!mode.wakeup_ctl || (i2c && start_seen && addr_hit)))
                           || (stop_cond && wcfg.irq_cause_sel);
  end

  always_ff @(posedge clk) begin
    if (rst)
      cpu_rdata <= scwm_pkg::RESET_VAL;
    else if (cpu_rd) begin
      case (cpu_addr)
        scwm_pkg::MODE_ADDR:  cpu_rdata <= {mode.channel_enable, addr_match, mode[5:0]};
        scwm_pkg::WAIT_ADDR:  cpu_rdata <= {1'b0, en & scl, wcfg[5:3], wait_release, wcfg[1:0]};
        scwm_pkg::SHIFT_ADDR: cpu_rdata <= lsb ? rev8(sio) : sio;
        scwm_pkg::SLAVE_ADDR: cpu_rdata <= slave_addr;
        default:              cpu_rdata <= 8'h00;
      endcase
    end
  end

  // Pin drive; stopped channel hands all pins to the port latches
  always_comb begin
    serial_clock_pin.o  = port_out[2];
    serial_clock_pin.oe = port_oe[2];
    serial_out_pin.o    = port_out[1];
    serial_out_pin.oe   = port_oe[1];
    serial_in_pin.o     = port_out[0];
    serial_in_pin.oe    = port_oe[0];
    if (en) begin
      if (i2c) begin
        serial_clock_pin.o  = 1'b0;
        serial_clock_pin.oe = (state == scwm_pkg::ST_SHIFT && master && !sck_gen)
                              || state == scwm_pkg::ST_WAIT
                              || (state == scwm_pkg::ST_IDLE && !wcfg.idle_clock_level_ctl);
        if (mode.bit_order_sel) begin
          serial_in_pin.o  = 1'b0;
          serial_in_pin.oe = state == scwm_pkg::ST_SHIFT && !so_bit;
        end else begin
          serial_out_pin.o  = 1'b0;
          serial_out_pin.oe = state == scwm_pkg::ST_SHIFT && !so_bit;
        end
      end else begin
        // External clock leaves the clock pin floating
        serial_clock_pin.o  = (state == scwm_pkg::ST_SHIFT) ? sck_gen : 1'b1;
        serial_clock_pin.oe = master;
        serial_out_pin.o    = so_bit;
        serial_out_pin.oe   = 1'b1;
      end
    end
  end

  a_len_nine_clocks: assert property (@(posedge clk) disable iff (rst)
    go && i2c && wcfg.wait_sel_hi && wcfg.wait_sel_lo |=> frame_len == scwm_pkg::BITS_9 && state == scwm_pkg::ST_SHIFT)
    else $error("nine-clock wait did not set a nine clock frame");

  a_len_eight_clocks: assert property (@(posedge clk) disable iff (rst)
    go && !(i2c && wcfg.wait_sel_hi && wcfg.wait_sel_lo) |=> frame_len == scwm_pkg::BITS_8)
    else $error("frame length not eight clocks");

  a_wait_holds_low: assert property (@(posedge clk) disable iff (rst)
    state == scwm_pkg::ST_WAIT |-> serial_clock_pin.oe && !serial_clock_pin.o)
    else $error("clock line not held low during wait");

  a_release_ends_wait: assert property (@(posedge clk) disable iff (rst)
    state == scwm_pkg::ST_WAIT && wait_release && en
      |=> state == scwm_pkg::ST_IDLE ##1 (!wait_release || $past(wr_wait)))
    else $error("wait release did not end the wait and clear");

  a_idle_clock_low: assert property (@(posedge clk) disable iff (rst)
    en && i2c && state == scwm_pkg::ST_IDLE && !wcfg.idle_clock_level_ctl
      |-> serial_clock_pin.oe && !serial_clock_pin.o)
    else $error("idle clock not driven low");

  a_idle_clock_float: assert property (@(posedge clk) disable iff (rst)
    en && i2c && state == scwm_pkg::ST_IDLE && wcfg.idle_clock_level_ctl |-> !serial_clock_pin.oe)
    else $error("idle clock not released");

  a_level_off_zero: assert property (@(posedge clk) disable iff (rst)
    cpu_rd && cpu_addr == scwm_pkg::WAIT_ADDR && !en |=> cpu_rdata[6] == 1'b0)
    else $error("clock level bit not zero while stopped");

  a_stopped_ports: assert property (@(posedge clk) disable iff (rst)
    !en |-> serial_clock_pin.o == port_out[2] && serial_clock_pin.oe == port_oe[2]
            && serial_out_pin.oe == port_oe[1] && serial_in_pin.oe == port_oe[0])
    else $error("stopped channel does not pass port latches");

  a_stopped_no_shift: assert property (@(posedge clk) disable iff (rst)
    !en |=> state == scwm_pkg::ST_IDLE && $stable(start_tgl))
    else $error("transfer started while stopped");

  a_stop_irq: assert property (@(posedge clk) disable iff (rst)
    stop_cond && wcfg.irq_cause_sel |=> channel_interrupt)
    else $error("stop condition did not interrupt");
endmodule : scwm_ctrl
`default_nettype wire

//--- scwm_link.sv
`timescale 1ns/1ps
`default_nettype none
module scwm_link (
  // Link clock domain
  input  wire logic       link_clk,
  input  wire logic       link_rst,
  // Quasi-static controls from the system domain
  input  wire logic       start_tgl,
  input  wire logic [3:0] frame_len,
  input  wire logic [7:0] tx_word,
  // Serial data
  input  wire logic       sdi,
  output logic            so_bit,
  // Results to the system domain
  output logic            done_tgl,
  output logic [7:0]      rx_word
);
  logic [3:0] cnt;
  logic [3:0] so_idx;
  logic       armed;

  // Controls settle long before the first link edge of a frame
  assign armed = start_tgl != done_tgl;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cnt      <= 4'h0;
      done_tgl <= 1'b0;
      rx_word  <= 8'h00;
    end else if (armed) begin
      if (cnt < 4'h8)
        rx_word <= {rx_word[6:0], sdi};
      if (4'(cnt + 4'h1) == frame_len) begin
        cnt      <= 4'h0;
        done_tgl <= start_tgl;
      end else begin
        cnt <= 4'(cnt + 4'h1);
      end
    end
  end

  always_ff @(negedge link_clk) begin
    if (link_rst)
      so_idx <= 4'h0;
    else
      so_idx <= cnt;
  end

  // Ninth clock leaves the line released for the acknowledge
  assign so_bit = (so_idx < 4'h8) ? tx_word[3'(4'h7 - so_idx)] : 1'b1;
endmodule : scwm_link
`default_nettype wire

//--- scwm_peer.sv
`timescale 1ns/1ps
`default_nettype none
module scwm_peer (
  // Wire levels seen by the peer
  input  wire logic sck,
  input  wire logic din,
  // Lines the peer drives
  output logic      sck_drv,
  output logic      sck_oe,
  output logic      dout
);
  logic [7:0] tx_q;
  logic [7:0] rx_q;

  initial begin
    sck_drv = 1'b1;
    sck_oe  = 1'b0;
    dout    = 1'b0;
    tx_q    = 8'h00;
    rx_q    = 8'h00;
  end

  // Spent bits come back inverted so a stale line never looks valid
  always @(negedge sck) begin
    dout <= tx_q[7];
    tx_q <= {tx_q[6:0], ~tx_q[7]};
  end

  always @(posedge sck) begin
    rx_q <= {rx_q[6:0], din};
  end

  // Clock parked high outside frames; n of 0 only loads the byte
  task automatic run(input logic [7:0] b, input int n);
    tx_q   = b;
    sck_oe = (n > 0);
    repeat (n) begin
      sck_drv = 1'b0;
      #6;
      sck_drv = 1'b1;
      #6;
    end
    sck_oe = 1'b0;
  endtask : run
endmodule : scwm_peer
`default_nettype wire

//--- scwm_pkg.sv
`default_nettype none
package scwm_pkg;
  // Register offsets on the CPU port
  localparam logic [15:0] MODE_ADDR  = 16'hff60;
  localparam logic [15:0] SHIFT_ADDR = 16'hff62;
  localparam logic [15:0] WAIT_ADDR  = 16'hff63;
  localparam logic [15:0] SLAVE_ADDR = 16'hff64;

  // Reset values and writable-bit masks
  localparam logic [7:0] RESET_VAL  = 8'h00;
  localparam logic [7:0] MODE_WMASK = 8'hbf;
  localparam logic [7:0] WAIT_WMASK = 8'h3b;

  // Address comparison masks
  localparam logic [7:0] MASK_ALL   = 8'hff;
  localparam logic [7:0] MASK_NO_B0 = 8'hfe;

  // Frame lengths in serial clocks
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;

  typedef enum logic [1:0] {
    WAIT_NONE = 2'h0,
    WAIT_BAD  = 2'h1,
    WAIT_8    = 2'h2,
    WAIT_9    = 2'h3
  } scwm_wait_code_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_SHIFT = 3'h2,
    ST_WAIT  = 3'h4
  } scwm_state_t;

  typedef struct packed {
    logic channel_enable;
    logic address_match_flag;
    logic wakeup_ctl;
    logic mode_sel_hi;
    logic mode_sel_mid;
    logic bit_order_sel;
    logic clk_src_hi;
    logic clk_src_lo;
  } scwm_mode_t;

  typedef struct packed {
    logic zero;
    logic clock_pin_level;
    logic irq_cause_sel;
    logic address_mask_sel;
    logic idle_clock_level_ctl;
    logic wait_release;
    logic wait_sel_hi;
    logic wait_sel_lo;
  } scwm_wait_t;

  typedef struct packed {
    logic o;
    logic oe;
  } scwm_pin_t;
endpackage : scwm_pkg
`default_nettype wire

//--- serial_channel_wait_mode_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module serial_channel_wait_mode_control_tb_top;
  localparam logic [15:0] MODE  = scwm_pkg::MODE_ADDR;
  localparam logic [15:0] SHIFT = scwm_pkg::SHIFT_ADDR;
  localparam logic [15:0] WAITR = scwm_pkg::WAIT_ADDR;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  logic                link_rst = 1'b1;
  logic [15:0]         cpu_addr = 16'h0000;
  logic                cpu_wr = 1'b0;
  logic                cpu_rd = 1'b0;
  logic [7:0]          cpu_wdata = 8'h00;
  logic [7:0]          cpu_rdata;
  logic                timer_two_output = 1'b0;
  logic                timer_clock_select = 1'b0;
  logic [1:0]          tick_cnt = 2'h0;
  logic [2:0]          port_out = 3'h4;
  logic [2:0]          port_oe = 3'h0;
  logic                sda_tb = 1'b1;
  logic                peer_sck;
  logic                peer_oe;
  logic                peer_dout;
  logic                channel_interrupt;
  scwm_pkg::scwm_pin_t ck;
  scwm_pkg::scwm_pin_t si;
  scwm_pkg::scwm_pin_t so;
  logic                sck_w;
  logic                si_w;
  logic                so_w;
  int                  err_count = 0;
  int                  n_compared = 0;
  int                  cycles = 0;
  logic [7:0]          rv;
  logic                got;

  // Wired-AND clock covers both push-pull and open-drain use
  assign sck_w = (ck.oe ? ck.o : 1'b1) & (peer_oe ? peer_sck : 1'b1);
  assign si_w  = si.oe ? si.o : peer_dout;
  assign so_w  = (so.oe ? so.o : 1'b1) & sda_tb;

  scwm_ctrl i_dut (
    .clk(clk), .rst(rst), .link_clk(sck_w), .link_rst(link_rst),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .timer_two_output(timer_two_output), .timer_clock_select(timer_clock_select),
    .port_out(port_out), .port_oe(port_oe), .serial_clock_pin_in(sck_w), .serial_in_pin_in(si_w),
    .serial_out_pin_in(so_w), .serial_clock_pin(ck), .serial_in_pin(si), .serial_out_pin(so),
    .channel_interrupt(channel_interrupt)
  );

  scwm_peer i_peer (
    .sck(sck_w), .din(so_w), .sck_drv(peer_sck), .sck_oe(peer_oe), .dout(peer_dout)
  );

  initial begin
    forever #10 clk = ~clk;
  end

  always @(negedge clk) begin
    tick_cnt           <= tick_cnt + 2'h1;
    timer_two_output   <= (tick_cnt == 2'h0);
    timer_clock_select <= (tick_cnt == 2'h2);
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_count++;
      final_report();
    end
  end

  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7 - i];
  endfunction : rev8

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk);
    cpu_addr  = a;
    cpu_wdata = d;
    cpu_wr    = 1'b1;
    @(negedge clk);
    cpu_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk);
    cpu_addr = a;
    cpu_rd   = 1'b1;
    @(negedge clk);
    cpu_rd = 1'b0;
    d      = cpu_rdata;
  endtask : rd

  task automatic wait_irq(output logic g);
    g = 1'b0;
    for (int i = 0; i < 400 && !g; i++) begin
      @(negedge clk);
      if (channel_interrupt === 1'b1) g = 1'b1;
    end
  endtask : wait_irq

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  initial begin
    logic [7:0] tx;
    logic [7:0] px;
    void'($urandom(77768));
    fork
      i_peer.run(8'h00, 4);
      repeat (3) @(negedge clk);
    join
    rst      = 1'b0;
    link_rst = 1'b0;
    rd(MODE, rv); `CHK(rv, 8'h00)
    rd(WAITR, rv); `CHK(rv, 8'h00)
    rd(16'hff61, rv); `CHK(rv, 8'h00)
    wr(WAITR, 8'hf3);
    rd(WAITR, rv); `CHK(rv, 8'h33)
    wr(WAITR, 8'h00);
    wr(MODE, 8'h40);
    rd(MODE, rv); `CHK(rv, 8'h00)
    $display("test registers done");
    // Clock port level kept high so the link sees no stray edges
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      port_out = {1'b1, 2'($urandom)};
      port_oe  = 3'($urandom);
      tx       = 8'($urandom);
      wr(SHIFT, tx);
      rd(SHIFT, rv); `CHK(rv, tx)
      `CHK({ck.oe, so.oe, si.oe}, port_oe)
      `CHK({ck.o, so.o, si.o}, port_out)
    end
    port_oe = 3'h0;
    $display("test stopped channel done");
    for (int i = 0; i < 6; i++) begin
      tx = 8'($urandom);
      px = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      wr(MODE, {5'h10, i[0], 1'b0, i[1]});
      wr(SHIFT, tx);
      repeat (2) @(negedge clk);
      i_peer.run(px, 8);
      wait_irq(got); `CHK(got, 1'b1)
      `CHK(ck.oe, 1'b0)
      `CHK(so.oe, 1'b1)
      `CHK(i_peer.rx_q, i[0] ? rev8(tx) : tx)
      rd(SHIFT, rv); `CHK(rv, i[0] ? rev8(px) : px)
    end
    $display("test external clock done");
    for (int j = 0; j < 2; j++) begin
      tx = 8'($urandom);
      px = 8'($urandom);
      wr(MODE, {7'h41, j[0]});
      i_peer.run(px, 0);
      wr(SHIFT, tx);
      wait_irq(got); `CHK(got, 1'b1)
      `CHK({ck.oe, ck.o}, 2'b11)
      `CHK(i_peer.rx_q, tx)
      rd(SHIFT, rv); `CHK(rv, px)
    end
    $display("test internal clock done");
    wr(MODE, 8'h98);
    for (int k = 0; k < 2; k++) begin
      wr(WAITR, {6'h02, 1'b1, k[0]});
      wr(SHIFT, 8'($urandom));
      // Mid-frame code change must not cut this byte's wait
      wr(WAITR, 8'h08);
      i_peer.run(8'hff, 8 + k);
      wait_irq(got); `CHK(got, 1'b1)
      `CHK({ck.oe, ck.o}, 2'b10)
      wr(WAITR, {4'h0, ~k[0], 2'b11, k[0]});
      @(negedge clk);
      `CHK({ck.oe, ck.o}, {k[0], 1'b0})
      repeat (3) @(negedge clk);
      rd(WAITR, rv); `CHK(rv, {1'b0, ~k[0], 2'b00, ~k[0], 2'b01, k[0]})
    end
    $display("test wait release done");
    for (int m = 0; m < 2; m++) begin
      wr(WAITR, {2'b00, ~m[0], 5'h08});
      repeat (4) @(negedge clk);
      sda_tb = 1'b0;
      repeat (4) @(negedge clk);
      sda_tb = 1'b1;
      wait_irq(got); `CHK(got, ~m[0])
    end
    $display("test stop condition done");
    wr(MODE, 8'hb8);
    for (int n = 0; n < 4; n++) begin
      rv = (n == 3) ? {7'($urandom) | 7'h01, 1'b0} : {7'h00, n != 0};
      wr(scwm_pkg::SLAVE_ADDR, rv);
      wr(WAITR, {3'b001, n[0], 4'h8});
      wr(SHIFT, 8'hff);
      // Start after the transfer start; an all-zero address keeps the data line still
      sda_tb = 1'b0;
      repeat (4) @(negedge clk);
      i_peer.run(8'h00, 8);
      wait_irq(got); `CHK(got, n < 2)
      rd(MODE, rv); `CHK(rv, {1'b1, n < 2, 6'h38})
      rd(SHIFT, rv); `CHK(rv, 8'h00)
      sda_tb = 1'b1;
      repeat (6) @(negedge clk);
    end
    $display("test wake-up address done");
    final_report();
  end
endmodule : serial_channel_wait_mode_control_tb_top
`default_nettype wire
